// ==== design/imr_master_rx.sv ====
// Function
// - START first; address direction bit selects mode
// - START issued only once bus is free
// - After START: flag set, status 0x08
// - Writing flag one clears it, continues
// - After read address: flag, status 0x38/0x40/0x48
// - Received byte readable when flag set
// - Repeated START reports 0x10, keeps bus
// - In 0x10 write address switches to transmitter
// - On 0x38 release bus or restart
// - Acknowledge enable picks ACK or NACK
// - On 0x48 restart, stop, or both
// - On 0x58 restart, stop, or both
// - STOP clears stop bit; START may follow
//
// Implementation choices: the APB slave port and the placing of the registers.
module imr_master_rx #(
    parameter int QUARTER = imr_pkg::QUARTER_CYCLES
) (
    input  logic                  clk_i,
    input  logic                  reset_i,
    input  imr_pkg::imr_apb_req_t apb_i,
    output imr_pkg::imr_apb_rsp_t apb_o,
    input  logic                  scl_i,
    output logic                  scl_o,
    output logic                  scl_oe_o,
    input  logic                  sda_i,
    output logic                  sda_o,
    output logic                  sda_oe_o,
    output logic                  irq_o
);
    import imr_pkg::*;

    imr_state_t       s;
    imr_state_t       n;
    logic             tick;
    logic             go;
    logic             hw_flag;
    logic             lost;
    logic             scl_hi;
    logic             sda_smp;
    logic             setup;
    logic             acc;
    logic             hit;
    logic             rxp;
    logic             drv;
    logic [31:0]      rd;
    logic [IRQ_W-1:0] ev;

    always_comb begin
        n       = s;
        ev      = '0;
        go      = 1'b0;
        hw_flag = 1'b0;
        lost    = 1'b0;
        rd      = '0;
        hit     = 1'b1;
        drv     = 1'b0;
        n.scl_m = {s.scl_m[0], scl_i};
        n.sda_m = {s.sda_m[0], sda_i};
        n.sda_q = s.sda_m[1];
        scl_hi  = s.scl_m[1];
        sda_smp = s.sda_m[1];
        rxp     = s.rx && !s.addr;
        tick    = (s.div == '0);
        n.div   = tick ? DIV_W'(QUARTER - 1) : s.div - DIV_W'(1);

        // Bus monitor: START seen marks busy, STOP seen frees it
        if (scl_hi && s.sda_q && !sda_smp) begin
            n.busy = 1'b1;
        end
        if (scl_hi && !s.sda_q && sda_smp) begin
            n.busy = 1'b0;
        end

        // APB slave, zero wait states
        setup = apb_i.psel && !apb_i.penable;
        acc   = apb_i.psel && apb_i.penable && s.apb.pready;
        case (apb_i.paddr)
            OFS_CTRL: rd = {24'h0, s.flag, s.ack_en, s.start_rq, s.stop_rq,
                            s.wcol, s.enable, 2'h0};
            OFS_STAT: rd = {24'h0, s.code};
            OFS_DATA: rd = {24'h0, s.data};
            OFS_IRQS: rd = {29'h0, s.irq_stat};
            OFS_IRQM: rd = {29'h0, s.irq_mask};
            default:  hit = 1'b0;
        endcase
        n.apb.pready = setup;
        if (setup) begin
            n.apb.prdata  = rd;
            n.apb.pslverr = !hit;
        end
        if (acc && hit && apb_i.pwrite) begin
            case (apb_i.paddr)
                OFS_CTRL: begin
                    n.ack_en   = apb_i.pwdata[CB_ACK];
                    n.start_rq = apb_i.pwdata[CB_STA];
                    n.stop_rq  = apb_i.pwdata[CB_STO];
                    n.enable   = apb_i.pwdata[CB_EN];
                    if (apb_i.pwdata[CB_FLAG] && s.flag) begin
                        n.flag = 1'b0;
                        go     = 1'b1;
                    end
                end
                OFS_DATA: begin
                    // Data may only change while the engine is parked
                    if (s.flag) begin
                        n.data = apb_i.pwdata[7:0];
                        n.wcol = 1'b0;
                    end else begin
                        n.wcol = 1'b1;
                    end
                end
                OFS_IRQM: n.irq_mask = apb_i.pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
        // Clears only what the read returned, so a later event survives
        if (acc && !apb_i.pwrite && apb_i.paddr == OFS_IRQS) begin
            n.irq_stat = s.irq_stat & ~s.apb.prdata[IRQ_W-1:0];
        end

        case (s.st)
            ST_IDLE: begin
                if (n.enable && n.start_rq) begin
                    n.st  = ST_WAIT;
                    n.rep = 1'b0;
                end
            end
            ST_WAIT: begin
                if (tick && !s.busy) begin
                    n.st = ST_START;
                    n.q  = 2'd0;
                end
            end
            ST_START: begin
                if (tick) begin
                    if (s.q == 2'd3) begin
                        n.st    = ST_HOLD;
                        n.owner = 1'b1;
                        hw_flag = 1'b1;
                        n.code  = s.rep ? CODE_RSTART : CODE_START;
                    end else if (s.q != 2'd1 || scl_hi) begin
                        n.q = s.q + 2'd1;
                    end
                end
            end
            ST_XFER: begin
                if (tick) begin
                    case (s.q)
                        // Waits here while a slave stretches the clock
                        2'd2: if (scl_hi) n.q = 2'd3;
                        2'd3: begin
                            n.q = 2'd0;
                            if (s.bitn < ACK_BIT) begin
                                if (!rxp && s.sh[7] && !sda_smp) begin
                                    lost = 1'b1;
                                end
                                n.sh   = {s.sh[6:0], sda_smp};
                                n.bitn = s.bitn + 4'd1;
                            end else begin
                                hw_flag = 1'b1;
                                n.st    = ST_HOLD;
                                n.addr  = 1'b0;
                                if (rxp) begin
                                    // NACK bit overridden by another master
                                    if (!s.ackd && !sda_smp) begin
                                        lost = 1'b1;
                                    end
                                    n.data = s.sh;
                                    n.code = s.ackd ? CODE_RX_ACK : CODE_RX_NAK;
                                end else if (s.addr && s.rx) begin
                                    n.code = sda_smp ? CODE_R_NACK : CODE_R_ACK;
                                end else if (s.addr) begin
                                    n.code = sda_smp ? CODE_W_NACK : CODE_W_ACK;
                                end else begin
                                    n.code = sda_smp ? CODE_D_NACK : CODE_D_ACK;
                                end
                            end
                        end
                        default: n.q = s.q + 2'd1;
                    endcase
                end
            end
            ST_HOLD: begin
                if (go) begin
                    n.q    = 2'd0;
                    n.bitn = 4'd0;
                    if (!s.owner) begin
                        n.st  = n.start_rq ? ST_WAIT : ST_IDLE;
                        n.rep = 1'b0;
                    end else if (n.stop_rq) begin
                        n.st = ST_STOP;
                    end else if (n.start_rq) begin
                        n.st  = ST_START;
                        n.rep = 1'b1;
                    end else if (s.code == CODE_START || s.code == CODE_RSTART) begin
                        n.st   = ST_XFER;
                        n.addr = 1'b1;
                        n.sh   = s.data;
                        n.rx   = s.data[0];
                    end else if (s.code == CODE_R_ACK || s.code == CODE_RX_ACK) begin
                        n.st   = ST_XFER;
                        n.ackd = n.ack_en;
                    end else if (!s.rx) begin
                        n.st = ST_XFER;
                        n.sh = s.data;
                    end
                end
            end
            ST_STOP: begin
                if (tick) begin
                    if (s.q == 2'd3) begin
                        n.owner       = 1'b0;
                        n.stop_rq     = 1'b0;
                        n.rep         = 1'b0;
                        ev[IB_STOP]   = 1'b1;
                        n.st          = n.start_rq ? ST_WAIT : ST_IDLE;
                    end else if (s.q != 2'd1 || scl_hi) begin
                        n.q = s.q + 2'd1;
                    end
                end
            end
            default: n.st = ST_IDLE;
        endcase

        if (lost) begin
            n.st        = ST_HOLD;
            n.owner     = 1'b0;
            n.code      = CODE_LOST;
            hw_flag     = 1'b1;
            ev[IB_LOST] = 1'b1;
        end
        // Hardware set wins over a software clear in the same cycle
        if (hw_flag) begin
            n.flag      = 1'b1;
            ev[IB_FLAG] = 1'b1;
        end
        if (!n.enable) begin
            n.st    = ST_IDLE;
            n.owner = 1'b0;
        end
        n.irq_stat = n.irq_stat | ev;
        n.irq      = |(n.irq_stat & n.irq_mask);

        // Line drivers; during data bits SDA only moves a quarter after SCL went low
        n.scl_oe = (n.st == ST_HOLD && n.owner)
                 || (n.st == ST_XFER && n.q < 2'd2)
                 || (n.st == ST_STOP && n.q == 2'd0)
                 || (n.st == ST_START && ((n.rep && n.q == 2'd0) || n.q == 2'd3));
        drv = (n.bitn < ACK_BIT) ? (!(n.rx && !n.addr) && !n.sh[7])
                                 : (n.rx && !n.addr && n.ackd);
        case (n.st)
            ST_START: n.sda_oe = (n.q >= 2'd2);
            ST_STOP:  n.sda_oe = (n.q != 2'd3);
            ST_XFER:  n.sda_oe = (n.q == 2'd1) ? drv : s.sda_oe;
            ST_HOLD:  n.sda_oe = n.owner && s.sda_oe;
            default:  n.sda_oe = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s      <= '0;
            s.code <= CODE_NONE;
        end else begin
            s <= n;
        end
    end

    assign apb_o    = s.apb;
    assign scl_oe_o = s.scl_oe;
    assign sda_oe_o = s.sda_oe;
    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign irq_o    = s.irq;

    start_free_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (s.st == ST_WAIT && n.st == ST_START) |-> !s.busy)
        else $error("START issued while bus busy");

    start_code_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (s.st == ST_START && n.st == ST_HOLD && !s.rep)
        |=> (s.flag && s.code == CODE_START && scl_oe_o))
        else $error("START did not report 0x08");

    flag_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (acc && apb_i.pwrite && apb_i.paddr == OFS_CTRL && apb_i.pwdata[CB_FLAG]
         && s.flag && !hw_flag) |=> !s.flag)
        else $error("Flag not cleared by write of one");

    addr_code_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (s.st == ST_XFER && s.addr && s.rx && n.st == ST_HOLD)
        |=> s.flag && (s.code == CODE_LOST || s.code == CODE_R_ACK
                       || s.code == CODE_R_NACK))
        else $error("Bad status after read address");

    rx_data_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ($rose(s.flag) && (s.code == CODE_RX_ACK || s.code == CODE_RX_NAK))
        |-> s.data == s.sh)
        else $error("Received byte not in data register");

    rstart_code_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (s.st == ST_START && s.rep && n.st == ST_HOLD)
        |=> s.code == CODE_RSTART && s.owner ##1 scl_oe_o)
        else $error("Repeated START not reported as 0x10");

    mode_sel_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (s.st == ST_HOLD && n.st == ST_XFER && n.addr)
        |=> s.rx == $past(s.data[0]))
        else $error("Direction bit did not select mode");

    arb_release_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (lost && n.enable) |=> (!scl_oe_o && !sda_oe_o && s.code == CODE_LOST))
        else $error("Bus not released after arbitration loss");

    ack_drive_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (s.st == ST_XFER && s.rx && !s.addr && s.bitn == ACK_BIT && s.q == 2'd2)
        |-> sda_oe_o == s.ackd)
        else $error("Wrong acknowledge driven");

    stop_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ($fell(s.st == ST_STOP) && s.enable) |-> (!s.stop_rq && !s.owner))
        else $error("Stop request not cleared after STOP");

    flag_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (s.flag && s.owner && s.st == ST_HOLD) [*2] |-> scl_oe_o)
        else $error("Clock not held low while flag set");

    stop_sel_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (s.st == ST_HOLD && go && s.owner && n.enable && n.stop_rq) |=> s.st == ST_STOP)
        else $error("Stop request did not start a STOP");

    rstart_sel_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (s.st == ST_HOLD && go && s.owner && n.enable && !n.stop_rq && n.start_rq)
        |=> (s.st == ST_START && s.rep))
        else $error("Start request did not start a repeated START");

    lost_retry_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (s.st == ST_HOLD && go && !s.owner && n.enable && n.start_rq) |=> s.st == ST_WAIT)
        else $error("Start request after lost arbitration not queued");
endmodule : imr_master_rx

// ==== design/imr_pkg.sv ====
package imr_pkg;
    localparam int CLK_PERIOD_NS  = 40;
    localparam int LINK_PERIOD_NS = 320;
    // Quarter of a serial bit, rounded up to whole clock cycles
    localparam int QUARTER_CYCLES = (LINK_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W          = 16;
    localparam int IRQ_W          = 3;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_IRQS = 8'h0C;
    localparam logic [7:0] OFS_IRQM = 8'h10;

    localparam int CB_FLAG = 7;
    localparam int CB_ACK  = 6;
    localparam int CB_STA  = 5;
    localparam int CB_STO  = 4;
    localparam int CB_WCOL = 3;
    localparam int CB_EN   = 2;

    localparam int IB_FLAG = 0;
    localparam int IB_LOST = 1;
    localparam int IB_STOP = 2;

    localparam logic [3:0] ACK_BIT = 4'h8;

    localparam logic [7:0] CODE_START  = 8'h08;
    localparam logic [7:0] CODE_RSTART = 8'h10;
    localparam logic [7:0] CODE_W_ACK  = 8'h18;
    localparam logic [7:0] CODE_W_NACK = 8'h20;
    localparam logic [7:0] CODE_D_ACK  = 8'h28;
    localparam logic [7:0] CODE_D_NACK = 8'h30;
    localparam logic [7:0] CODE_LOST   = 8'h38;
    localparam logic [7:0] CODE_R_ACK  = 8'h40;
    localparam logic [7:0] CODE_R_NACK = 8'h48;
    localparam logic [7:0] CODE_RX_ACK = 8'h50;
    localparam logic [7:0] CODE_RX_NAK = 8'h58;
    localparam logic [7:0] CODE_NONE   = 8'hF8;

    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT, ST_START, ST_XFER, ST_HOLD, ST_STOP
    } imr_st_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } imr_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } imr_apb_rsp_t;

    typedef struct packed {
        imr_st_t          st;
        logic [1:0]       q;
        logic [3:0]       bitn;
        logic [7:0]       sh;
        logic [7:0]       data;
        logic [7:0]       code;
        logic             flag;
        logic             ack_en;
        logic             start_rq;
        logic             stop_rq;
        logic             wcol;
        logic             enable;
        logic             owner;
        logic             rx;
        logic             addr;
        logic             ackd;
        logic             rep;
        logic             busy;
        logic [DIV_W-1:0] div;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic             irq;
        logic             scl_oe;
        logic             sda_oe;
        logic [1:0]       scl_m;
        logic [1:0]       sda_m;
        logic             sda_q;
        imr_apb_rsp_t     apb;
    } imr_state_t;
endpackage : imr_pkg

// ==== verif/imr_slave_model.sv ====
module imr_slave_model #(
    parameter logic [6:0] ADDR = 7'h50,
    parameter logic [7:0] FIRST = 8'hC3
) (
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] sh;
    logic [7:0] tx;
    int         n;
    logic       act;
    logic       is_addr;
    logic       rd;
    logic       pend;

    initial begin
        sda_oe_o = 1'b0;
        act      = 1'b0;
        rd       = 1'b0;
        pend     = 1'b0;
        n        = 0;
    end

    // START seen: fresh address phase
    always @(negedge sda_i) begin
        if (scl_i) begin
            act     = 1'b1;
            is_addr = 1'b1;
            n       = 0;
            pend    = 1'b0;
            rd      = 1'b0;
            tx      = FIRST;
        end
    end

    // STOP seen: let go of the line at once
    always @(posedge sda_i) begin
        if (scl_i) begin
            act      = 1'b0;
            sda_oe_o = 1'b0;
        end
    end

    always @(posedge scl_i) begin
        if (act && n < 8) begin
            sh = {sh[6:0], sda_i};
        end else if (act && rd) begin
            // Master NACK ends the read
            act = !sda_i;
            tx  = tx + 8'h11;
        end
        n = (n == 8) ? 0 : n + 1;
    end

    // Data changes only while the clock is low
    always @(negedge scl_i) begin
        if (n == 0) begin
            rd = pend;
        end
        if (!act) begin
            sda_oe_o = 1'b0;
        end else if (n == 8 && !rd) begin
            sda_oe_o = !is_addr || sh[7:1] == ADDR;
            pend     = is_addr ? sh[0] : pend;
            act      = sda_oe_o;
            is_addr  = 1'b0;
        end else if (rd && n < 8) begin
            sda_oe_o = !tx[7 - n];
        end else begin
            sda_oe_o = 1'b0;
        end
    end
endmodule : imr_slave_model

// ==== verif/imr_master_rx_tb.sv ====
module imr_master_rx_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import imr_pkg::*;

    localparam logic [6:0] ADDR = 7'h50;
    // First byte the slave sends; later bytes step by 0x11
    localparam logic [7:0] FIRST = 8'hC3;

    logic         clk_i = 1'b0;
    logic         reset_i;
    imr_apb_req_t apb_i;
    imr_apb_rsp_t apb_o;
    logic         scl_o;
    logic         scl_oe_o;
    logic         sda_o;
    logic         sda_oe_o;
    logic         irq_o;
    logic         slv_oe;
    logic         jam;
    wire          scl_w;
    wire          sda_w;
    int           n_mismatch;
    int           samples_checked;

    // Open-drain wires with pull-ups
    assign scl_w = !scl_oe_o;
    assign sda_w = !(sda_oe_o || slv_oe || jam);

    always #20 clk_i = ~clk_i;

    imr_master_rx imr_master_rx_inst (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .apb_i    (apb_i),
        .apb_o    (apb_o),
        .scl_i    (scl_w),
        .scl_o    (scl_o),
        .scl_oe_o (scl_oe_o),
        .sda_i    (sda_w),
        .sda_o    (sda_o),
        .sda_oe_o (sda_oe_o),
        .irq_o    (irq_o)
    );

    imr_slave_model #(.ADDR(ADDR), .FIRST(FIRST)) imr_slave_model_inst (
        .scl_i    (scl_w),
        .sda_i    (sda_w),
        .sda_oe_o (slv_oe)
    );

    task automatic results();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic timeout(input string what);
        n_mismatch++;
        $display("wrong value %s: expected done, seen stuck", what);
        results();
    endtask : timeout

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_i);
        apb_i.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (apb_o.pready !== 1'b1 && k < 50);
        if (apb_o.pready !== 1'b1) timeout("pready");
        r = apb_o.prdata;
        e = apb_o.pslverr;
        apb_i <= '0;
        // Idle edge keeps each request apart
        @(posedge clk_i);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        rd(a, r);
        chk(what, exp, r);
    endtask : rchk

    task automatic stat(input logic [7:0] code);
        logic [31:0] r;
        rd(OFS_STAT, r);
        chk("status", {24'h0, code}, r & 32'hF8);
    endtask : stat

    task automatic wait_bit(input int b, input logic v);
        logic [31:0] r;
        int          k;
        k = 0;
        do begin
            rd(OFS_CTRL, r);
            k++;
        end while (r[b] !== v && k < 300);
        if (r[b] !== v) timeout("ctrl bit");
    endtask : wait_bit

    task automatic step(input logic [7:0] ctrl, input logic [7:0] code);
        wr(OFS_CTRL, {24'h0, ctrl});
        wait_bit(CB_FLAG, 1'b1);
        stat(code);
    endtask : step

    task automatic stop();
        wr(OFS_CTRL, 32'h94);
        wait_bit(CB_STO, 1'b0);
        repeat (20) @(posedge clk_i);
        chk("lines", 32'h0, {30'h0, scl_oe_o, sda_oe_o});
    endtask : stop

    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        stat(CODE_NONE);
        rchk(OFS_CTRL, 32'h0, "ctrl");
        chk("pins", 32'h0, {30'h0, scl_o, sda_o});
        chk("lines", 32'h0, {29'h0, scl_oe_o, sda_oe_o, irq_o});
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk("pslverr", 32'h1, {31'h0, e});
        // Data write with flag low is refused
        wr(OFS_DATA, 32'h55);
        rchk(OFS_CTRL, 32'h08, "ctrl");
        rchk(OFS_DATA, 32'h0, "data");
    endtask : t_reset

    task automatic t_read();
        wr(OFS_IRQM, 32'h1);
        step(8'hA4, CODE_START);
        chk("irq_o", 32'h1, {31'h0, irq_o});
        chk("scl_oe_o", 32'h1, {31'h0, scl_oe_o});
        rchk(OFS_IRQS, 32'h1, "irq_stat");
        repeat (2) @(posedge clk_i);
        chk("irq_o", 32'h0, {31'h0, irq_o});
        wr(OFS_DATA, {24'h0, ADDR, 1'b1});
        step(8'h84, CODE_R_ACK);
        step(8'hC4, CODE_RX_ACK);
        rchk(OFS_DATA, {24'h0, FIRST}, "data");
        step(8'h84, CODE_RX_NAK);
        rchk(OFS_DATA, {24'h0, FIRST + 8'h11}, "data");
        stop();
        rchk(OFS_IRQS, 32'h5, "irq_stat");
    endtask : t_read

    task automatic t_nack();
        logic [31:0] r;
        step(8'hA4, CODE_START);
        wr(OFS_DATA, 32'hB1);
        step(8'h84, CODE_R_NACK);
        step(8'hA4, CODE_RSTART);
        chk("scl_oe_o", 32'h1, {31'h0, scl_oe_o});
        wr(OFS_DATA, {24'h0, ADDR, 1'b0});
        step(8'h84, CODE_W_ACK);
        // Now a transmitter: one data byte, acknowledged by the slave
        wr(OFS_DATA, 32'h3C);
        step(8'h84, CODE_D_ACK);
        step(8'hB4, CODE_START);
        rd(OFS_CTRL, r);
        chk("stop bit", 32'h0, {31'h0, r[CB_STO]});
        wr(OFS_DATA, {24'h0, ADDR, 1'b1});
        step(8'h84, CODE_R_ACK);
        step(8'h84, CODE_RX_NAK);
        step(8'hA4, CODE_RSTART);
        wr(OFS_DATA, 32'hB1);
        step(8'h84, CODE_R_NACK);
        stop();
        // Write address nobody answers
        step(8'hA4, CODE_START);
        wr(OFS_DATA, 32'hB0);
        step(8'h84, CODE_W_NACK);
        stop();
    endtask : t_nack

    task automatic t_lost();
        logic [31:0] r;
        wr(OFS_IRQM, 32'h0);
        rd(OFS_IRQS, r);
        step(8'hA4, CODE_START);
        wr(OFS_DATA, {24'h0, ADDR, 1'b1});
        // Rival master holds SDA low through the first address bit
        jam <= 1'b1;
        step(8'h84, CODE_LOST);
        chk("irq_o", 32'h0, {31'h0, irq_o});
        rchk(OFS_IRQS, 32'h3, "irq_stat");
        wr(OFS_CTRL, 32'h84);
        repeat (10) @(posedge clk_i);
        chk("lines", 32'h0, {30'h0, scl_oe_o, sda_oe_o});
        wr(OFS_CTRL, 32'hA4);
        repeat (40) @(posedge clk_i);
        chk("lines", 32'h0, {30'h0, scl_oe_o, sda_oe_o});
        // Releasing SDA with SCL high is the rival's STOP
        jam <= 1'b0;
        wait_bit(CB_FLAG, 1'b1);
        stat(CODE_START);
        // Second loss, cleared with start request set this time
        wr(OFS_DATA, {24'h0, ADDR, 1'b1});
        jam <= 1'b1;
        step(8'h84, CODE_LOST);
        wr(OFS_CTRL, 32'hA4);
        repeat (40) @(posedge clk_i);
        chk("lines", 32'h0, {30'h0, scl_oe_o, sda_oe_o});
        jam <= 1'b0;
        wait_bit(CB_FLAG, 1'b1);
        stat(CODE_START);
        stop();
    endtask : t_lost

    initial begin
        apb_i           = '0;
        reset_i         = 1'b1;
        jam             = 1'b0;
        n_mismatch      = 0;
        samples_checked = 0;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_read();
        t_nack();
        t_lost();
        results();
    end
endmodule : imr_master_rx_tb
